// >>> hdl/hmf_pkg.sv
// package: register map, field positions and constants of the fifo control block
package hmf_pkg;
   localparam logic [7:0] TX_CFG_ADDR = 8'h70;
   localparam logic [7:0] RX_DP_ADDR = 8'h78;
   localparam logic [7:0] RX_LVL_ADDR = 8'h7c;
   localparam logic [7:0] RX_CFG_ADDR = 8'h6c;
   localparam logic [7:0] INT_STS_ADDR = 8'h60;
   localparam logic [7:0] INT_MASK_ADDR = 8'h64;
   localparam int STOP_BIT = 0;
   localparam int TXON_BIT = 1;
   localparam int SAO_BIT = 2;
   localparam int TXD_FLUSH_BIT = 14;
   localparam int TXS_FLUSH_BIT = 15;
   localparam int SKIP_BIT = 31;
   localparam int OFF_LSB = 8;
   localparam int OFF_MSB = 12;
   localparam int SUSED_LSB = 16;
   localparam int SUSED_MSB = 23;
   localparam int DUSED_LSB = 0;
   localparam int DUSED_MSB = 15;
   localparam int IRQ_W = 3;
   localparam int IRQ_TX_STATUS_FULL_IRQ = 0;
   localparam int IRQ_STOPPED = 1;
   localparam int IRQ_SKIPDONE = 2;
   localparam logic [4:0] OFF_RESET = 5'h00;
   localparam logic [15:0] BYTES_PER_WORD = 16'h0004;
   localparam logic [1:0] WORD_LOW_MASK = 2'h3;
   typedef enum logic [1:0] {
      HMF_IDLE = 2'b00,
      HMF_SEND = 2'b01,
      HMF_HOLD = 2'b11
   } hmf_tx_t;
endpackage : hmf_pkg

// >>> hdl/hmf_sync2.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module hmf_sync2 #(
   parameter int W = 1
) (
   input wire logic refClk,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hmf_sync_t;
   hmf_sync_t st_reg;
   hmf_sync_t st_next;
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.s1 = din;
         st_next.s2 = st_reg.s1;
      end
   end
   always_ff @(posedge refClk) begin
      st_reg <= st_next;
   end
   assign dout = st_reg.s2;
endmodule : hmf_sync2
`default_nettype wire

// >>> hdl/hmf_fifo_ctrl.sv
// host mac fifo control: transmit control, receive offset, skip and levels
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RQ1) receive data start shifts by programmed offset 0..31 bytes, bits 12:8
// (RQ2) host changes offset low two bits only with receiver halted and purged
// (RQ3) upper offset bits change anytime; new value applies at next frame read
// (RQ4) writing one to bit 15 flushes transmit status fifo, self-clears
// (RQ5) writing one to bit 14 flushes transmit data fifo, self-clears
// (RQ6) overrun-allow clear: transmission pauses while status fifo is full
// (RQ7) status-fifo-full interrupt flag raises regardless of overrun-allow
// (RQ8) transmitter enable set: frames in transmit data fifo are sent
// (RQ9) stop requested and transmitter halted clears transmitter enable
// (RQ10) stop bit finishes current frame, then halts; stop bit then clears
// (RQ11) writes to stop bit ignored while it reads one
// (RQ12) bit 31 write skips to next receive frame; reads high until done
// (RQ13) host must not read receive data fifo while skip bit is high
// (RQ14) bits 23:16 report receive status fifo occupancy in words
// (RQ15) bits 15:0 report receive data bytes, frame length rounded to words
// (RQ16) reserved bits read zero; writes to read-only fields ignored
module hmf_fifo_ctrl #(
   parameter int SUSED_W = 8,
   parameter int DUSED_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic irq,
   // mac-side status, from pins of the mac core
   input wire logic txDataAvail,
   input wire logic txFrameEnd,
   input wire logic txStatFull,
   input wire logic rxFrameDone,
   input wire logic [DUSED_W-1:0] rxFrameLen,
   input wire logic rxStatPush,
   input wire logic rxStatPop,
   input wire logic rxDataPop,
   input wire logic rxSkipDone,
   input wire logic rxFrameStart,
   // mac-side controls
   output logic txGo,
   output logic txStatFlush,
   output logic txDataFlush,
   output logic rxSkipReq,
   output logic [4:0] rxStartByteShift
);
   // every check runs on the system clock and sleeps through reset
   default clocking hmf_cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // all mac inputs come from another clock domain, so synchronise them
   localparam int SW = 9;
   logic [SW-1:0] syncIn;
   logic [SW-1:0] syncOut;
   logic [DUSED_W-1:0] lenSync;
   assign syncIn = {txDataAvail, txFrameEnd, txStatFull, rxFrameDone,
      rxStatPush, rxStatPop, rxDataPop, rxSkipDone, rxFrameStart};
   hmf_sync2 #(.W(SW)) uSync (
      .refClk(ref_clk),
      .ce(clkEn),
      .din(syncIn),
      .dout(syncOut)
   );
   // frame length is stable while rxFrameDone is synchronised
   hmf_sync2 #(.W(DUSED_W)) uLen (
      .refClk(ref_clk),
      .ce(clkEn),
      .din(rxFrameLen),
      .dout(lenSync)
   );
   logic sDataAvail, sFrameEnd, sStatFull, sFrameDone;
   logic sStatPush, sStatPop, sDataPop, sSkipDone, sFrameStart;
   assign {sDataAvail, sFrameEnd, sStatFull, sFrameDone, sStatPush,
      sStatPop, sDataPop, sSkipDone, sFrameStart} = syncOut;

   function automatic logic [DUSED_W-1:0] roundWord(
      input logic [DUSED_W-1:0] len);
      logic [DUSED_W-1:0] r;
      r = len;
      if ((len[1:0] & hmf_pkg::WORD_LOW_MASK) != 2'h0)
         r = (len | DUSED_W'(hmf_pkg::WORD_LOW_MASK)) + DUSED_W'(1);
      return r;
   endfunction : roundWord

   typedef struct packed {
      hmf_pkg::hmf_tx_t txState;
      logic txOn;
      logic stopReq;
      logic allowOver;
      logic txsFlush;
      logic txdFlush;
      logic skip;
      logic [4:0] offActive;
      logic [4:0] offProg;
      logic [SUSED_W-1:0] statUsed;
      logic [DUSED_W-1:0] dataUsed;
      logic [hmf_pkg::IRQ_W-1:0] intSts;
      logic [hmf_pkg::IRQ_W-1:0] intMask;
      logic fullPrev;
      logic [31:0] rdata;
      logic irqOut;
      logic go;
   } hmf_state_t;
   hmf_state_t st_reg;
   hmf_state_t st_next;

   logic wrTx, wrDp, wrCfg, wrMask, rdSts;
   assign wrTx = regWr && regAddr == hmf_pkg::TX_CFG_ADDR;
   assign wrDp = regWr && regAddr == hmf_pkg::RX_DP_ADDR;
   assign wrCfg = regWr && regAddr == hmf_pkg::RX_CFG_ADDR;
   assign wrMask = regWr && regAddr == hmf_pkg::INT_MASK_ADDR;
   assign rdSts = regRd && regAddr == hmf_pkg::INT_STS_ADDR;

   logic [hmf_pkg::IRQ_W-1:0] evt;

   always_comb begin
      st_next = st_reg;
      evt = '0;
      // self-clearing flush strobes last one cycle
      st_next.txsFlush = 1'b0;
      st_next.txdFlush = 1'b0;
      if (wrTx) begin
         st_next.allowOver = regWdata[hmf_pkg::SAO_BIT];
         st_next.txOn = regWdata[hmf_pkg::TXON_BIT];
         if (!st_reg.stopReq)
            st_next.stopReq = regWdata[hmf_pkg::STOP_BIT]; // RQ11
         st_next.txsFlush = regWdata[hmf_pkg::TXS_FLUSH_BIT]; // RQ4
         st_next.txdFlush = regWdata[hmf_pkg::TXD_FLUSH_BIT]; // RQ5
      end
      if (wrCfg)
         st_next.offProg = regWdata[hmf_pkg::OFF_MSB:hmf_pkg::OFF_LSB]; // RQ1
      // offset takes effect only between frames, never mid-read
      if (sFrameStart || !st_reg.txOn && st_reg.txState == hmf_pkg::HMF_IDLE
            && st_reg.dataUsed == '0)
         st_next.offActive = st_reg.offProg; // RQ3
      if (wrMask)
         st_next.intMask = regWdata[hmf_pkg::IRQ_W-1:0];
      if (wrDp && regWdata[hmf_pkg::SKIP_BIT])
         st_next.skip = 1'b1; // RQ12
      else if (sSkipDone && st_reg.skip) begin
         st_next.skip = 1'b0; // RQ12
         evt[hmf_pkg::IRQ_SKIPDONE] = 1'b1;
      end
      // transmit sequencing
      unique case (st_reg.txState)
         hmf_pkg::HMF_IDLE: begin
            if (st_reg.stopReq) begin
               st_next.stopReq = 1'b0; // RQ10
               st_next.txOn = 1'b0; // RQ9
               evt[hmf_pkg::IRQ_STOPPED] = 1'b1;
            end else if (st_reg.txOn && sDataAvail
                  && (st_reg.allowOver || !sStatFull))
               st_next.txState = hmf_pkg::HMF_SEND; // RQ8 RQ6
         end
         hmf_pkg::HMF_SEND: begin
            if (!st_reg.allowOver && sStatFull)
               st_next.txState = hmf_pkg::HMF_HOLD; // RQ6
            else if (sFrameEnd)
               st_next.txState = hmf_pkg::HMF_IDLE; // RQ10
         end
         hmf_pkg::HMF_HOLD: begin
            if (st_reg.allowOver || !sStatFull)
               st_next.txState = hmf_pkg::HMF_SEND; // RQ6
         end
         default: st_next.txState = hmf_pkg::HMF_IDLE;
      endcase
      st_next.go = st_next.txState == hmf_pkg::HMF_SEND;
      // full flag rises on the edge, independent of overrun-allow
      st_next.fullPrev = sStatFull;
      if (sStatFull && !st_reg.fullPrev)
         evt[hmf_pkg::IRQ_TX_STATUS_FULL_IRQ] = 1'b1; // RQ7
      // receive levels
      if (sStatPush && !sStatPop)
         st_next.statUsed = st_reg.statUsed + SUSED_W'(1); // RQ14
      else if (sStatPop && !sStatPush && st_reg.statUsed != '0)
         st_next.statUsed = st_reg.statUsed - SUSED_W'(1); // RQ14
      begin
         logic [DUSED_W-1:0] d;
         d = st_reg.dataUsed;
         if (sFrameDone)
            d = d + roundWord(lenSync); // RQ15
         if (sDataPop && d >= DUSED_W'(hmf_pkg::BYTES_PER_WORD))
            d = d - DUSED_W'(hmf_pkg::BYTES_PER_WORD); // RQ15
         st_next.dataUsed = d;
      end
      // read data, one cycle later; reserved bits zero
      st_next.rdata = '0; // RQ16
      if (regRd) begin
         unique case (regAddr)
            hmf_pkg::TX_CFG_ADDR: begin
               st_next.rdata[hmf_pkg::SAO_BIT] = st_reg.allowOver;
               st_next.rdata[hmf_pkg::TXON_BIT] = st_reg.txOn;
               st_next.rdata[hmf_pkg::STOP_BIT] = st_reg.stopReq;
            end
            hmf_pkg::RX_DP_ADDR:
               st_next.rdata[hmf_pkg::SKIP_BIT] = st_reg.skip; // RQ12
            hmf_pkg::RX_LVL_ADDR: begin
               st_next.rdata[hmf_pkg::SUSED_MSB:hmf_pkg::SUSED_LSB] =
                  st_reg.statUsed; // RQ14
               st_next.rdata[hmf_pkg::DUSED_MSB:hmf_pkg::DUSED_LSB] =
                  st_reg.dataUsed; // RQ15
            end
            hmf_pkg::RX_CFG_ADDR:
               st_next.rdata[hmf_pkg::OFF_MSB:hmf_pkg::OFF_LSB] =
                  st_reg.offProg;
            hmf_pkg::INT_STS_ADDR:
               st_next.rdata[hmf_pkg::IRQ_W-1:0] = st_reg.intSts;
            hmf_pkg::INT_MASK_ADDR:
               st_next.rdata[hmf_pkg::IRQ_W-1:0] = st_reg.intMask;
            default: st_next.rdata = '0;
         endcase
      end
      // read clears status, but a same-cycle event wins
      st_next.intSts = (rdSts ? '0 : st_reg.intSts) | evt;
      st_next.irqOut = |(st_next.intSts & st_next.intMask);
      if (!clkEn)
         st_next = st_reg;
      if (rst) begin
         st_next = '0;
         st_next.txState = hmf_pkg::HMF_IDLE;
         st_next.offProg = hmf_pkg::OFF_RESET;
         st_next.offActive = hmf_pkg::OFF_RESET;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_reg <= st_next;
   end

   assign regRdata = st_reg.rdata;
   assign irq = st_reg.irqOut;
   assign txGo = st_reg.go;
   assign txStatFlush = st_reg.txsFlush;
   assign txDataFlush = st_reg.txdFlush;
   assign rxSkipReq = st_reg.skip;
   assign rxStartByteShift = st_reg.offActive;

   // flush: a write raises the strobe, which then drops by itself
   sequence s_txs_flush_wr;
      clkEn && wrTx && regWdata[hmf_pkg::TXS_FLUSH_BIT];
   endsequence
   // a back-to-back flush write or a frozen clock may stretch the pulse
   sequence s_txs_flush_pulse;
      txStatFlush ##1 (!txStatFlush || $past(wrTx) || !$past(clkEn));
   endsequence
   a_flush_pulse: assert property ( // RQ4
      s_txs_flush_wr |=> s_txs_flush_pulse)
      else $error("status flush not a pulse");
   a_data_flush: assert property ( // RQ5
      clkEn && wrTx && regWdata[hmf_pkg::TXD_FLUSH_BIT] |=> txDataFlush)
      else $error("data flush missing");
   a_flush_self_clear: assert property ( // RQ4 RQ5
      clkEn && !wrTx |=> !txStatFlush && !txDataFlush)
      else $error("flush strobe stuck high");

   a_hold_full: assert property ( // RQ6
      st_reg.txState == hmf_pkg::HMF_HOLD |-> !st_reg.allowOver
      || !clkEn || st_next.txState == hmf_pkg::HMF_SEND)
      else $error("hold with overrun allowed");
   a_hold_enter: assert property ( // RQ6
      clkEn && st_reg.txState == hmf_pkg::HMF_SEND && !st_reg.allowOver
      && sStatFull |=> st_reg.txState == hmf_pkg::HMF_HOLD && !txGo)
      else $error("full status fifo did not pause");
   a_allow_run: assert property ( // RQ6
      clkEn && st_reg.txState == hmf_pkg::HMF_SEND && st_reg.allowOver
      && !sFrameEnd |=> txGo)
      else $error("overrun allowed but paused");
   a_full_flag: assert property ( // RQ7
      clkEn && sStatFull && !st_reg.fullPrev |=>
      st_reg.intSts[hmf_pkg::IRQ_TX_STATUS_FULL_IRQ])
      else $error("full flag not set");
   a_stop_clears: assert property ( // RQ9 RQ10
      clkEn && st_reg.stopReq && st_reg.txState == hmf_pkg::HMF_IDLE
      |=> !st_reg.stopReq && !st_reg.txOn)
      else $error("stop did not clear enable");
   a_stop_event: assert property ( // RQ10
      clkEn && st_reg.stopReq && st_reg.txState == hmf_pkg::HMF_IDLE
      |=> st_reg.intSts[hmf_pkg::IRQ_STOPPED])
      else $error("stopped event missing");
   a_stop_sticky: assert property ( // RQ11
      st_reg.stopReq && st_reg.txState != hmf_pkg::HMF_IDLE |=>
      st_reg.stopReq)
      else $error("stop dropped early");
   a_go_enable: assert property ( // RQ8
      txGo && $past(st_reg.txState) == hmf_pkg::HMF_IDLE |->
      $past(st_reg.txOn))
      else $error("sent while disabled");

   // skip: raised by a write, dropped by the far side's answer
   sequence s_skip_wr;
      clkEn && wrDp && regWdata[hmf_pkg::SKIP_BIT];
   endsequence
   sequence s_skip_answer;
      clkEn && st_reg.skip && sSkipDone && !wrDp;
   endsequence
   a_skip_hold: assert property ( // RQ12
      s_skip_wr |=> rxSkipReq)
      else $error("skip not raised");
   a_skip_clear: assert property ( // RQ12
      s_skip_answer |=> !rxSkipReq && st_reg.intSts[hmf_pkg::IRQ_SKIPDONE])
      else $error("skip not cleared on answer");

   a_read_zero: assert property ( // RQ16
      $past(regRd) && $past(regAddr) == hmf_pkg::RX_DP_ADDR && $past(clkEn)
      |-> regRdata[hmf_pkg::SKIP_BIT-1:0] == '0)
      else $error("reserved bits nonzero");
   a_read_idle: assert property ( // RQ16
      clkEn && !regRd |=> regRdata == '0)
      else $error("read data outside the read slot");
   a_offset_range: assert property ( // RQ1
      clkEn && wrCfg |=> st_reg.offProg ==
      $past(regWdata[hmf_pkg::OFF_MSB:hmf_pkg::OFF_LSB]))
      else $error("offset not stored");
   a_offset_apply: assert property ( // RQ3
      clkEn && sFrameStart |=> rxStartByteShift == $past(st_reg.offProg))
      else $error("offset not applied at frame start");
   a_stat_count: assert property ( // RQ14
      clkEn && sStatPush && !sStatPop |=> st_reg.statUsed ==
      $past(st_reg.statUsed) + SUSED_W'(1))
      else $error("status level wrong");
   a_stat_down: assert property ( // RQ14
      clkEn && sStatPop && !sStatPush && st_reg.statUsed != '0 |=>
      st_reg.statUsed == $past(st_reg.statUsed) - SUSED_W'(1))
      else $error("status level not lowered");
   // an empty status fifo must not wrap to full on a stray pop
   a_stat_floor: assert property ( // RQ14
      clkEn && sStatPop && !sStatPush && st_reg.statUsed == '0 |=>
      st_reg.statUsed == '0)
      else $error("status level wrapped");
   // rounding written independently of the helper function
   localparam logic [DUSED_W-1:0] RND = DUSED_W'(hmf_pkg::WORD_LOW_MASK);
   a_data_count: assert property ( // RQ15
      clkEn && sFrameDone && !sDataPop |=> st_reg.dataUsed ==
      $past(st_reg.dataUsed) + $past((lenSync + RND) & ~RND))
      else $error("data level not raised by rounded length");
   // a low enable must freeze every bit of state, strobes included
   a_freeze: assert property (
      !clkEn |=> $stable(st_reg))
      else $error("state moved while frozen");
endmodule : hmf_fifo_ctrl
`default_nettype wire

// >>> verif/hmf_mac_model.sv
// mac-side model: ends transmit frames and answers receive skip requests
`timescale 1ns/1ps
`default_nettype none
module hmf_mac_model #(
   parameter int FRAME_CYC = 30,
   parameter int SKIP_CYC = 6
) (
   input wire logic ref_clk,
   input wire logic txGo,
   input wire logic rxSkipReq,
   output logic txFrameEnd,
   output logic rxSkipDone
);
   int txCnt = 0;
   int skCnt = 0;
   logic skPrev = 1'b0;
   initial begin
      txFrameEnd = 1'b0;
      rxSkipDone = 1'b0;
   end
   // a paused transmitter restarts its frame count, the harsher reading
   always @(posedge ref_clk) begin
      txFrameEnd <= 1'b0;
      rxSkipDone <= 1'b0;
      skPrev <= rxSkipReq;
      if (!txGo) begin
         txCnt <= 0;
      end else if (txCnt == FRAME_CYC - 1) begin
         txFrameEnd <= 1'b1;
         txCnt <= 0;
      end else begin
         txCnt <= txCnt + 1;
      end
      // one answer per request, not per cycle of the level
      if (rxSkipReq && !skPrev) begin
         skCnt <= SKIP_CYC;
      end else if (skCnt > 0) begin
         skCnt <= skCnt - 1;
         rxSkipDone <= (skCnt == 1);
      end
   end
endmodule : hmf_mac_model
`default_nettype wire

// >>> verif/host_mac_fifo_control_bench.sv
// self-checking bench for the host mac fifo control block
`timescale 1ns/1ps
`default_nettype none
module host_mac_fifo_control_bench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h00000000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic irq, txGo, txStatFlush, txDataFlush, rxSkipReq, txFrameEnd, rxSkipDone;
   logic [4:0] rxStartByteShift;
   logic txDataAvail = 1'b0;
   logic txStatFull = 1'b0;
   logic rxFrameDone = 1'b0;
   logic [15:0] rxFrameLen = 16'h0000;
   logic rxStatPush = 1'b0;
   logic rxStatPop = 1'b0;
   logic rxDataPop = 1'b0;
   logic rxFrameStart = 1'b0;
   logic clkEn = 1'b1;
   int badCount = 0;
   int samplesChecked = 0;
   int cycles = 0;

   hmf_fifo_ctrl i_hmf_fifo_ctrl (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .irq(irq), .txDataAvail(txDataAvail),
      .txFrameEnd(txFrameEnd), .txStatFull(txStatFull),
      .rxFrameDone(rxFrameDone), .rxFrameLen(rxFrameLen),
      .rxStatPush(rxStatPush), .rxStatPop(rxStatPop), .rxDataPop(rxDataPop),
      .rxSkipDone(rxSkipDone), .rxFrameStart(rxFrameStart), .txGo(txGo),
      .txStatFlush(txStatFlush), .txDataFlush(txDataFlush),
      .rxSkipReq(rxSkipReq), .rxStartByteShift(rxStartByteShift));
   hmf_mac_model i_hmf_mac_model (.ref_clk(ref_clk), .txGo(txGo),
      .rxSkipReq(rxSkipReq), .txFrameEnd(txFrameEnd), .rxSkipDone(rxSkipDone));

   always #4 ref_clk = ~ref_clk;

   task automatic conclude();
      $display("checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   // a hung handshake must still reach the verdict
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         badCount++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samplesChecked++;
      if (g !== e) begin
         badCount++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask : rdchk

   task automatic poll(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      int n;
      n = 0;
      rd(a, d);
      while (d !== e && n < 60) begin
         rd(a, d);
         n++;
      end
      chk(d, e);
   endtask : poll

   task automatic rx_frame(input logic [15:0] len);
      @(posedge ref_clk);
      rxFrameLen <= len;
      @(posedge ref_clk);
      rxFrameDone <= 1'b1;
      @(posedge ref_clk);
      rxFrameDone <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : rx_frame

   task automatic frame_start();
      @(posedge ref_clk);
      rxFrameStart <= 1'b1;
      @(posedge ref_clk);
      rxFrameStart <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : frame_start

   task automatic t_reset();
      rdchk(hmf_pkg::TX_CFG_ADDR, 32'h00000000);
      rdchk(hmf_pkg::RX_DP_ADDR, 32'h00000000);
      rdchk(hmf_pkg::RX_LVL_ADDR, 32'h00000000);
      rdchk(8'h40, 32'h00000000);
   endtask : t_reset

   task automatic t_offset();
      wr(hmf_pkg::RX_CFG_ADDR, 32'h00001f00);
      frame_start();
      chk({27'h0, rxStartByteShift}, 32'h0000001f);
   endtask : t_offset

   task automatic t_tx();
      wr(hmf_pkg::INT_MASK_ADDR, 32'h00000001);
      txDataAvail <= 1'b1;
      wr(hmf_pkg::TX_CFG_ADDR, 32'h00000002);
      repeat (6) @(posedge ref_clk);
      chk({31'h0, txGo}, 32'h00000001);
      txStatFull <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({31'h0, txGo}, 32'h00000000);
      chk({31'h0, irq}, 32'h00000001);
      rdchk(hmf_pkg::INT_STS_ADDR, 32'h00000001);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h00000000);
      wr(hmf_pkg::TX_CFG_ADDR, 32'h00000006);
      repeat (4) @(posedge ref_clk);
      chk({31'h0, txGo}, 32'h00000001);
      txDataAvail <= 1'b0;
      wr(hmf_pkg::TX_CFG_ADDR, 32'h00000007);
      wr(hmf_pkg::TX_CFG_ADDR, 32'h00000006);
      rdchk(hmf_pkg::TX_CFG_ADDR, 32'h00000007);
      poll(hmf_pkg::TX_CFG_ADDR, 32'h00000004);
      chk({31'h0, txGo}, 32'h00000000);
      rdchk(hmf_pkg::INT_STS_ADDR, 32'h00000002);
      txStatFull <= 1'b0;
   endtask : t_tx

   task automatic t_flush();
      wr(hmf_pkg::TX_CFG_ADDR, 32'h0000c004);
      #1 chk({30'h0, txStatFlush, txDataFlush}, 32'h00000003);
      @(posedge ref_clk);
      #1 chk({30'h0, txStatFlush, txDataFlush}, 32'h00000000);
      rdchk(hmf_pkg::TX_CFG_ADDR, 32'h00000004);
   endtask : t_flush

   // a write offered while the enable is low must leave no trace
   task automatic t_freeze();
      @(posedge ref_clk);
      clkEn <= 1'b0;
      wr(hmf_pkg::TX_CFG_ADDR, 32'h00000003);
      clkEn <= 1'b1;
      rdchk(hmf_pkg::TX_CFG_ADDR, 32'h00000004);
      chk({31'h0, txGo}, 32'h00000000);
   endtask : t_freeze

   // no receive data pops are issued while the skip is in flight
   task automatic t_skip();
      wr(hmf_pkg::RX_DP_ADDR, 32'h80000000);
      rdchk(hmf_pkg::RX_DP_ADDR, 32'h80000000);
      chk({31'h0, rxSkipReq}, 32'h00000001);
      poll(hmf_pkg::RX_DP_ADDR, 32'h00000000);
      chk({31'h0, irq}, 32'h00000000);
      rdchk(hmf_pkg::INT_STS_ADDR, 32'h00000004);
   endtask : t_skip

   task automatic t_levels();
      rx_frame(16'h0005);
      rx_frame(16'h0008);
      @(posedge ref_clk);
      rxStatPush <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rxStatPush <= 1'b0;
      rxStatPop <= 1'b1;
      rxDataPop <= 1'b1;
      @(posedge ref_clk);
      rxStatPop <= 1'b0;
      rxDataPop <= 1'b0;
      wr(hmf_pkg::RX_LVL_ADDR, 32'hffffffff);
      repeat (4) @(posedge ref_clk);
      rdchk(hmf_pkg::RX_LVL_ADDR, 32'h0001000c);
      wr(hmf_pkg::RX_CFG_ADDR, 32'hffffe3ff);
      rdchk(hmf_pkg::RX_CFG_ADDR, 32'h00000300);
      frame_start();
      chk({27'h0, rxStartByteShift}, 32'h00000003);
   endtask : t_levels

   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_offset();
      t_tx();
      t_flush();
      t_freeze();
      t_skip();
      t_levels();
      conclude();
   end
endmodule : host_mac_fifo_control_bench
`default_nettype wire
